// ### saces_pkg.sv
// Constants and carrier types for the sensor alarm and receive error status bank
package saces_pkg;

  localparam int unsigned SENS_W   = 3;
  localparam int unsigned NUM_SENS = 3;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned LANE_MAX = 2;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_ALARM_FLAGS = 8'h57;
  localparam logic [ADDR_W-1:0] ADDR_RSVD_5B     = 8'h5B;
  localparam logic [ADDR_W-1:0] ADDR_ERR_CNT     = 8'h5C;
  localparam logic [ADDR_W-1:0] ADDR_ERR_FLAGS   = 8'h5D;
  localparam logic [ADDR_W-1:0] ADDR_LANE01      = 8'h5E;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL     = 8'h93;
  localparam logic [ADDR_W-1:0] ADDR_LIVE        = 8'h94;
  // Index 0 pin 0, index 1 pin 1, index 2 internal temperature
  localparam logic [ADDR_W-1:0] ADDR_EXT [NUM_SENS] = '{8'h58, 8'h59, 8'h5A};
  localparam logic [ADDR_W-1:0] ADDR_LIM [NUM_SENS] = '{8'h90, 8'h91, 8'h92};

  // Field positions
  localparam int unsigned PEAK_LSB       = 4;
  localparam int unsigned TROUGH_LSB     = 0;
  localparam int unsigned EXT_RSV_HI_BIT = 7;
  localparam int unsigned EXT_RSV_LO_BIT = 3;
  localparam int unsigned ERR_SHORT_BIT  = 3;
  localparam int unsigned ERR_PAYLD_BIT  = 2;
  localparam int unsigned ERR_HDR2_BIT   = 1;
  localparam int unsigned ERR_HDR1_BIT   = 0;
  localparam int unsigned LANE_STRIDE    = 4;
  localparam int unsigned LANE_SOFT_OFS  = 3;
  localparam int unsigned LANE_HARD_OFS  = 2;
  localparam int unsigned LANE_CTRL_OFS  = 1;
  localparam int unsigned CTRL_MON_BIT   = 0;
  localparam int unsigned CTRL_ERR_BIT   = 1;
  localparam int unsigned CTRL_LCLR_BIT  = 2;

  // Reset values and write mask
  localparam logic [SENS_W-1:0] PEAK_RST    = 3'h0;
  localparam logic [SENS_W-1:0] TROUGH_RST  = 3'h7;
  localparam logic [SENS_W-1:0] UPPER_RST   = 3'h7;
  localparam logic [SENS_W-1:0] LOWER_RST   = 3'h0;
  localparam logic [DATA_W-1:0] CTRL_RST    = 8'h03;
  localparam logic [DATA_W-1:0] RSV5B_MASK  = 8'hFC;
  localparam logic [DATA_W-1:0] ZERO_WORD   = 8'h00;
  localparam logic [3:0]        ERR_FLG_RST = 4'h0;

  typedef struct packed {
    logic              valid;
    logic [SENS_W-1:0] value;
  } saces_sample_t;

  typedef struct packed {
    logic bad_packet;
    logic short_line_flag;
    logic payload_check_fail;
    logic header_double_error;
    logic header_single_error;
  } saces_pkt_err_t;

  typedef struct packed {
    logic sync_soft_error;
    logic sync_hard_error;
    logic request_ctrl_error;
  } saces_lane_err_t;

endpackage

// ### saces_top.sv
// Sensor alarm flags, extreme readings and receive error status registers
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps

module saces_top
  import saces_pkg::*;
#(
  parameter int unsigned NUM_LANES = 2,
  parameter int unsigned ERR_CNT_W = 8
) (
  input  wire logic                          MCLK_IN,
  input  wire logic                          RSTN_IN,
  input  wire logic [ADDR_W-1:0]             ADDR_IN,
  input  wire logic [DATA_W-1:0]             WDATA_IN,
  input  wire logic                          WR_IN,
  input  wire logic                          RD_IN,
  output logic      [DATA_W-1:0]             RDATA_OUT,
  input  wire saces_sample_t [NUM_SENS-1:0]  SAMPLE_IN,
  input  wire saces_pkt_err_t                PKT_ERR_IN,
  input  wire saces_lane_err_t [NUM_LANES-1:0] LANE_ERR_IN
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (NUM_LANES < 1 || NUM_LANES > LANE_MAX) begin : g_bad_lanes
    $error("NUM_LANES must be 1 or 2");
  end
  if (ERR_CNT_W < 1 || ERR_CNT_W > DATA_W) begin : g_bad_cnt
    $error("ERR_CNT_W must be 1 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [DATA_W-1:0]    ctrl_r;
  logic                 mon_en;
  logic                 err_en;
  logic                 lane_clr;
  logic                 flags_rd;
  logic                 cnt_rd;
  logic                 err_rd;
  logic                 rsv5b_wr;
  logic                 ctrl_wr;
  logic [DATA_W-1:0]    rsv5b_r;
  logic [ERR_CNT_W-1:0] err_cnt_r;
  logic [ERR_CNT_W-1:0] err_cnt_nxt;
  logic [ERR_CNT_W-1:0] err_cnt_base;
  logic [3:0]           err_flags_r;
  logic [3:0]           err_flags_nxt;
  logic [3:0]           err_events;
  logic [DATA_W-1:0]    rdata_nxt;
  logic [DATA_W-1:0]    rdata_r;

  wire  [NUM_SENS-1:0]  high_flag;
  wire  [NUM_SENS-1:0]  low_flag;
  wire  [NUM_SENS-1:0]  live_over;
  wire  [NUM_SENS-1:0]  live_under;
  wire  [DATA_W-1:0]    ext_word [NUM_SENS];
  wire  [DATA_W-1:0]    lim_word [NUM_SENS];
  wire  [DATA_W-1:0]    lane_word;
  wire  [DATA_W-1:0]    alarm_word;
  wire  [DATA_W-1:0]    live_word;

  ////////////////////////////////////////////////////////////////////////////
  // Access decode

  assign mon_en   = ctrl_r[CTRL_MON_BIT];
  assign err_en   = ctrl_r[CTRL_ERR_BIT];
  assign flags_rd = RD_IN && (ADDR_IN == ADDR_ALARM_FLAGS);
  assign cnt_rd   = RD_IN && (ADDR_IN == ADDR_ERR_CNT);
  assign err_rd   = RD_IN && (ADDR_IN == ADDR_ERR_FLAGS);
  assign rsv5b_wr = WR_IN && (ADDR_IN == ADDR_RSVD_5B);
  assign ctrl_wr  = WR_IN && (ADDR_IN == ADDR_CONTROL);
  assign lane_clr = ctrl_wr && WDATA_IN[CTRL_LCLR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Control and spare storage

  // Clear bit is a write-only pulse, never stored
  always_ff @(posedge MCLK_IN) begin
    if (!RSTN_IN) begin
      ctrl_r <= CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_r <= {6'h00, WDATA_IN[CTRL_ERR_BIT], WDATA_IN[CTRL_MON_BIT]};
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RSTN_IN) begin
      rsv5b_r <= ZERO_WORD;
    end else if (rsv5b_wr) begin
      rsv5b_r <= WDATA_IN & RSV5B_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-sensor alarm flags, extremes and limits

  for (genvar s = 0; s < NUM_SENS; s++) begin : g_sens
    logic              ext_rd;
    logic              ext_wr;
    logic              lim_wr;
    logic              over;
    logic              under;
    logic              high_r;
    logic              low_r;
    logic              over_r;
    logic              under_r;
    logic              rsv_hi_r;
    logic              rsv_lo_r;
    logic [SENS_W-1:0] upper_r;
    logic [SENS_W-1:0] lower_r;
    logic [SENS_W-1:0] peak_r;
    logic [SENS_W-1:0] peak_nxt;
    logic [SENS_W-1:0] trough_r;
    logic [SENS_W-1:0] trough_nxt;

    assign ext_rd = RD_IN && (ADDR_IN == ADDR_EXT[s]);
    assign ext_wr = WR_IN && (ADDR_IN == ADDR_EXT[s]);
    assign lim_wr = WR_IN && (ADDR_IN == ADDR_LIM[s]);
    assign over   = mon_en && SAMPLE_IN[s].valid && (SAMPLE_IN[s].value > upper_r);
    assign under  = mon_en && SAMPLE_IN[s].valid && (SAMPLE_IN[s].value < lower_r);

    always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN) begin
        upper_r <= UPPER_RST;
        lower_r <= LOWER_RST;
      end else if (lim_wr) begin
        upper_r <= WDATA_IN[PEAK_LSB +: SENS_W];
        lower_r <= WDATA_IN[TROUGH_LSB +: SENS_W];
      end
    end

    always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN) begin
        rsv_hi_r <= 1'b0;
        rsv_lo_r <= 1'b0;
      end else if (ext_wr) begin
        rsv_hi_r <= WDATA_IN[EXT_RSV_HI_BIT];
        rsv_lo_r <= WDATA_IN[EXT_RSV_LO_BIT];
      end
    end

    // Set has priority over the clearing read
    always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN) begin
        high_r <= 1'b0;
      end else if (over) begin
        high_r <= 1'b1;
      end else if (flags_rd) begin
        high_r <= 1'b0;
      end
    end

    always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN) begin
        low_r <= 1'b0;
      end else if (under) begin
        low_r <= 1'b1;
      end else if (flags_rd) begin
        low_r <= 1'b0;
      end
    end

    // Clear first, then fold in this cycle's reading
    always_comb begin
      peak_nxt = ext_rd ? PEAK_RST : peak_r;
      if (over && (SAMPLE_IN[s].value > peak_nxt)) begin
        peak_nxt = SAMPLE_IN[s].value;
      end
    end

    always_comb begin
      trough_nxt = ext_rd ? TROUGH_RST : trough_r;
      if (under && (SAMPLE_IN[s].value < trough_nxt)) begin
        trough_nxt = SAMPLE_IN[s].value;
      end
    end

    always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN) begin
        peak_r   <= PEAK_RST;
        trough_r <= TROUGH_RST;
      end else begin
        peak_r   <= peak_nxt;
        trough_r <= trough_nxt;
      end
    end

    // Region of the most recent valid sample
    always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN) begin
        over_r  <= 1'b0;
        under_r <= 1'b0;
      end else if (SAMPLE_IN[s].valid) begin
        over_r  <= over;
        under_r <= under;
      end
    end

    assign high_flag[s]  = high_r;
    assign low_flag[s]   = low_r;
    assign live_over[s]  = over_r;
    assign live_under[s] = under_r;
    assign ext_word[s]   = {rsv_hi_r, peak_r, rsv_lo_r, trough_r};
    assign lim_word[s]   = {1'b0, upper_r, 1'b0, lower_r};
  end

  // Pin 0 in bits 1:0, pin 1 in 3:2, temperature in 5:4, high above low
  assign alarm_word = {2'b00,
                       high_flag[2], low_flag[2],
                       high_flag[1], low_flag[1],
                       high_flag[0], low_flag[0]};
  assign live_word  = {2'b00,
                       live_over[2], live_under[2],
                       live_over[1], live_under[1],
                       live_over[0], live_under[0]};

  ////////////////////////////////////////////////////////////////////////////
  // Receive packet error counter and flags

  always_comb begin
    err_cnt_base = cnt_rd ? '0 : err_cnt_r;
    err_cnt_nxt  = err_cnt_base;
    // Saturates rather than wrapping
    if (err_en && PKT_ERR_IN.bad_packet && !(&err_cnt_base)) begin
      err_cnt_nxt = err_cnt_base + 1'b1;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RSTN_IN) begin
      err_cnt_r <= '0;
    end else begin
      err_cnt_r <= err_cnt_nxt;
    end
  end

  always_comb begin
    err_events                = 4'h0;
    err_events[ERR_SHORT_BIT] = PKT_ERR_IN.short_line_flag;
    err_events[ERR_PAYLD_BIT] = PKT_ERR_IN.payload_check_fail;
    err_events[ERR_HDR2_BIT]  = PKT_ERR_IN.header_double_error;
    err_events[ERR_HDR1_BIT]  = PKT_ERR_IN.header_single_error;
    if (!err_en) begin
      err_events = 4'h0;
    end
    err_flags_nxt = (err_rd ? ERR_FLG_RST : err_flags_r) | err_events;
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RSTN_IN) begin
      err_flags_r <= ERR_FLG_RST;
    end else begin
      err_flags_r <= err_flags_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-lane sync and control errors

  for (genvar l = 0; l < LANE_MAX; l++) begin : g_lane
    logic soft_r;
    logic hard_r;
    logic ctrl_err_r;
    logic soft_ev;
    logic hard_ev;
    logic ctrl_ev;

    if (l < NUM_LANES) begin : g_used
      assign soft_ev = err_en && LANE_ERR_IN[l].sync_soft_error;
      assign hard_ev = err_en && LANE_ERR_IN[l].sync_hard_error;
      assign ctrl_ev = err_en && LANE_ERR_IN[l].request_ctrl_error;
    end else begin : g_absent
      assign soft_ev = 1'b0;
      assign hard_ev = 1'b0;
      assign ctrl_ev = 1'b0;
    end

    // Held until reset or a lane clear; a new event beats the clear
    always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN) begin
        soft_r <= 1'b0;
      end else if (soft_ev) begin
        soft_r <= 1'b1;
      end else if (lane_clr) begin
        soft_r <= 1'b0;
      end
    end

    always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN) begin
        hard_r <= 1'b0;
      end else if (hard_ev) begin
        hard_r <= 1'b1;
      end else if (lane_clr) begin
        hard_r <= 1'b0;
      end
    end

    always_ff @(posedge MCLK_IN) begin
      if (!RSTN_IN) begin
        ctrl_err_r <= 1'b0;
      end else if (ctrl_ev) begin
        ctrl_err_r <= 1'b1;
      end else if (lane_clr) begin
        ctrl_err_r <= 1'b0;
      end
    end

    assign lane_word[l*LANE_STRIDE + LANE_SOFT_OFS] = soft_r;
    assign lane_word[l*LANE_STRIDE + LANE_HARD_OFS] = hard_r;
    assign lane_word[l*LANE_STRIDE + LANE_CTRL_OFS] = ctrl_err_r;
    assign lane_word[l*LANE_STRIDE]                 = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Old contents are sampled here while the same edge applies the clear
  always_comb begin
    rdata_nxt = ZERO_WORD;
    unique case (ADDR_IN)
      ADDR_ALARM_FLAGS: rdata_nxt = alarm_word;
      ADDR_RSVD_5B:     rdata_nxt = rsv5b_r;
      ADDR_ERR_CNT:     rdata_nxt = DATA_W'(err_cnt_r);
      ADDR_ERR_FLAGS:   rdata_nxt = {4'h0, err_flags_r};
      ADDR_LANE01:      rdata_nxt = lane_word;
      ADDR_CONTROL:     rdata_nxt = ctrl_r;
      ADDR_LIVE:        rdata_nxt = live_word;
      default:          rdata_nxt = ZERO_WORD;
    endcase
    for (int i = 0; i < NUM_SENS; i++) begin
      if (ADDR_IN == ADDR_EXT[i]) begin
        rdata_nxt = ext_word[i];
      end
      if (ADDR_IN == ADDR_LIM[i]) begin
        rdata_nxt = lim_word[i];
      end
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RSTN_IN) begin
      rdata_r <= ZERO_WORD;
    end else if (RD_IN) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= ZERO_WORD;
    end
  end

  assign RDATA_OUT = rdata_r;

endmodule // saces_top

// ### saces_properties.sv
// Concurrent checks on the status bank ports
`timescale 1ns/100ps
module saces_properties
  import saces_pkg::*;
#(
  parameter int unsigned NUM_LANES = 2,
  parameter int unsigned ERR_CNT_W = 8
) (
  input wire logic                            MCLK_IN,
  input wire logic                            RSTN_IN,
  input wire logic [ADDR_W-1:0]               ADDR_IN,
  input wire logic [DATA_W-1:0]               WDATA_IN,
  input wire logic                            WR_IN,
  input wire logic                            RD_IN,
  input wire logic [DATA_W-1:0]               RDATA_OUT,
  input wire saces_sample_t [NUM_SENS-1:0]    SAMPLE_IN,
  input wire saces_pkt_err_t                  PKT_ERR_IN,
  input wire saces_lane_err_t [NUM_LANES-1:0] LANE_ERR_IN
);
  logic [DATA_W-1:0] lim_r [NUM_SENS];
  logic [1:0]        ctl_r;
  logic              rd57;
  logic [7:0]        lane_f;
  logic [NUM_SENS-1:0] samp_v;
  assign rd57   = RD_IN && ADDR_IN == ADDR_ALARM_FLAGS;
  assign lane_f = {LANE_ERR_IN[1], 1'b0, LANE_ERR_IN[0], 1'b0};
  ////////////////////////////////////////
  // Shadow of limits and enables
  always_ff @(posedge MCLK_IN) begin
    if (!RSTN_IN) begin
      ctl_r <= 2'h3;
      for (int i = 0; i < NUM_SENS; i++) lim_r[i] <= 8'h70;
    end else if (WR_IN) begin
      if (ADDR_IN == ADDR_CONTROL) ctl_r <= WDATA_IN[1:0];
      for (int i = 0; i < NUM_SENS; i++) if (ADDR_IN == ADDR_LIM[i]) lim_r[i] <= WDATA_IN;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RSTN_IN);
  for (genvar s = 0; s < NUM_SENS; s++) begin : g_sens
    logic over;
    logic under;
    assign over  = ctl_r[0] && SAMPLE_IN[s].valid && SAMPLE_IN[s].value > lim_r[s][6:4];
    assign under = ctl_r[0] && SAMPLE_IN[s].valid && SAMPLE_IN[s].value < lim_r[s][2:0];
    assign samp_v[s] = SAMPLE_IN[s].valid;
    chk_high_flag: assert property (
      over ##1 !RD_IN ##1 rd57 |=> RDATA_OUT[2*s+1]) else $error("high flag missing");
    chk_low_flag: assert property (
      under ##1 !RD_IN ##1 rd57 |=> RDATA_OUT[2*s]) else $error("low flag missing");
    chk_peak_kept: assert property (
      over ##1 !RD_IN ##1 RD_IN && ADDR_IN == ADDR_EXT[s]
      |=> RDATA_OUT[6:4] >= $past(SAMPLE_IN[s].value, 3)) else $error("peak too low");
    chk_trough_kept: assert property (
      under ##1 !RD_IN ##1 RD_IN && ADDR_IN == ADDR_EXT[s]
      |=> RDATA_OUT[2:0] <= $past(SAMPLE_IN[s].value, 3)) else $error("trough too high");
  end
  chk_flags_cleared: assert property (
    rd57 && samp_v == '0 ##1 !RD_IN && samp_v == '0 ##1 rd57 && samp_v == '0
    |=> RDATA_OUT == 8'h00) else $error("alarm flags not cleared");
  chk_count_restart: assert property (
    RD_IN && ADDR_IN == ADDR_ERR_CNT && !PKT_ERR_IN.bad_packet
    ##1 !RD_IN && !PKT_ERR_IN.bad_packet
    ##1 RD_IN && ADDR_IN == ADDR_ERR_CNT && !PKT_ERR_IN.bad_packet
    |=> RDATA_OUT == 8'h00) else $error("count not restarted");
  chk_count_step: assert property (
    ctl_r[1] && PKT_ERR_IN.bad_packet ##1 !RD_IN ##1 RD_IN && ADDR_IN == ADDR_ERR_CNT
    |=> RDATA_OUT != 8'h00) else $error("bad packet not counted");
  chk_pkt_flags: assert property (
    ctl_r[1] && PKT_ERR_IN[3:0] != 4'h0 ##1 !RD_IN ##1 RD_IN && ADDR_IN == ADDR_ERR_FLAGS
    |=> (RDATA_OUT[3:0] & $past(PKT_ERR_IN[3:0], 3)) == $past(PKT_ERR_IN[3:0], 3)
    && RDATA_OUT[7:4] == 4'h0) else $error("packet flag missing");
  chk_lane_flags: assert property (
    ctl_r[1] && lane_f != 8'h00 ##1 !RD_IN && !WR_IN ##1 RD_IN && ADDR_IN == ADDR_LANE01
    |=> (RDATA_OUT & $past(lane_f, 3)) == $past(lane_f, 3) && RDATA_OUT[4] == 1'b0
    && RDATA_OUT[0] == 1'b0) else $error("lane flag missing");
  chk_rdata_idle: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
    else $error("read data outside read slot");
  cover property (rd57 ##1 RDATA_OUT != 8'h00);
  cover property (RD_IN && ADDR_IN == ADDR_ERR_CNT ##1 RDATA_OUT == 8'hff);
  cover property (RD_IN && ADDR_IN == ADDR_LANE01 ##1 RDATA_OUT != 8'h00);
endmodule // saces_properties

bind saces_top saces_properties #(.NUM_LANES(NUM_LANES), .ERR_CNT_W(ERR_CNT_W)) u_props (
  .MCLK_IN(MCLK_IN), .RSTN_IN(RSTN_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .SAMPLE_IN(SAMPLE_IN),
  .PKT_ERR_IN(PKT_ERR_IN), .LANE_ERR_IN(LANE_ERR_IN)
);

// ### saces_csi_source.sv
// Receive-side error source standing in for the image sensor link
`timescale 1ns/100ps
module saces_csi_source
  import saces_pkg::*;
#(
  parameter int unsigned NUM_LANES = 2
) (
  input  wire logic                            clk_in,
  input  wire logic                            go_in,
  input  wire saces_pkt_err_t                  pkt_in,
  input  wire saces_lane_err_t [NUM_LANES-1:0] lane_in,
  output saces_pkt_err_t                       pkt_out,
  output saces_lane_err_t [NUM_LANES-1:0]      lane_out
);
  // Each report is a single-cycle pulse
  always @(posedge clk_in) begin
    pkt_out <= go_in ? pkt_in : '0;
    lane_out <= go_in ? lane_in : '0;
  end
endmodule // saces_csi_source

// ### saces_tb.sv
// Self-checking bench for the sensor alarm and receive error status bank
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("[ERR] %0t got %h expected %h", $time, got, exp); \
    end \
  end
module testbench
  import saces_pkg::*;
;
  logic                         clk = 1'b0;
  logic                         rstn = 1'b0;
  logic [ADDR_W-1:0]            addr = 8'h00;
  logic [DATA_W-1:0]            wdata = 8'h00;
  logic                         wr = 1'b0;
  logic                         rd = 1'b0;
  logic                         rd_d = 1'b0;
  logic                         go = 1'b0;
  logic [DATA_W-1:0]            rdata;
  logic [DATA_W-1:0]            exp_v;
  logic [DATA_W-1:0]            acc;
  logic [2:0]                   vhi;
  logic [2:0]                   vlo;
  logic [31:0]                  rng = 32'h0000_b1c4;
  saces_sample_t [NUM_SENS-1:0] samp = '0;
  saces_pkt_err_t               pkt_cmd = '0;
  saces_pkt_err_t               pkt_err;
  saces_lane_err_t [1:0]        lane_cmd = '0;
  saces_lane_err_t [1:0]        lane_err;
  logic [DATA_W-1:0]            expq [$];
  int                           checked = 0;
  int                           miscompares = 0;
  int                           cyc = 0;
  saces_top #(.NUM_LANES(2), .ERR_CNT_W(8)) dut (
    .MCLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr),
    .RD_IN(rd), .RDATA_OUT(rdata), .SAMPLE_IN(samp), .PKT_ERR_IN(pkt_err),
    .LANE_ERR_IN(lane_err)
  );
  saces_csi_source #(.NUM_LANES(2)) u_src (
    .clk_in(clk), .go_in(go), .pkt_in(pkt_cmd), .lane_in(lane_cmd),
    .pkt_out(pkt_err), .lane_out(lane_err)
  );
  initial begin
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    expq.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic sample(input int s, input logic [2:0] v);
    @(posedge clk);
    samp[s] <= '{1'b1, v};
    @(posedge clk);
    samp[s].valid <= 1'b0;
  endtask
  task automatic report(input logic [4:0] p, input logic [5:0] l);
    @(posedge clk);
    go <= 1'b1;
    pkt_cmd <= p;
    lane_cmd <= l;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
  endtask
  task automatic close_out();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) begin
      exp_v = expq.pop_front();
      `CHK(rdata, exp_v)
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) rd_reg(8'(8'h57 + i), (i inside {[1:3]}) ? 8'h07 : 8'h00);
    rd_reg(8'h20, 8'h00);
    wr_reg(8'h20, 8'haa);
    wr_reg(ADDR_ALARM_FLAGS, 8'hff);
    rd_reg(8'h20, 8'h00);
    rd_reg(ADDR_ALARM_FLAGS, 8'h00);
    for (int s = 0; s < 3; s++) begin
      rng = xs(rng);
      vhi = 3'h6 + 3'(rng[0]);
      vlo = 3'(rng[1]);
      wr_reg(ADDR_LIM[s], 8'h52);
      // Readings equal to a limit must not trip it
      sample(s, 3'h5);
      sample(s, 3'h2);
      sample(s, vlo);
      sample(s, 3'h1);
      sample(s, 3'h6);
      sample(s, vhi);
      rd_reg(ADDR_EXT[s], {1'b0, vhi, 1'b0, vlo});
      rd_reg(ADDR_EXT[s], 8'h07);
      rd_reg(ADDR_ALARM_FLAGS, 8'(8'h03 << (2 * s)));
      rd_reg(ADDR_ALARM_FLAGS, 8'h00);
    end
    sample(1, 3'h0);
    rd_reg(ADDR_ALARM_FLAGS, 8'h04);
    sample(1, 3'h0);
    rd_reg(ADDR_EXT[1], 8'h00);
    fork
      sample(0, 3'h7);
      rd_reg(ADDR_ALARM_FLAGS, 8'h04);
    join
    rd_reg(ADDR_ALARM_FLAGS, 8'h02);
    rd_reg(ADDR_EXT[0], 8'h77);
    rd_reg(ADDR_LIVE, 8'h26);
    wr_reg(ADDR_EXT[2], 8'h88);
    rd_reg(ADDR_EXT[2], 8'h8f);
    wr_reg(ADDR_RSVD_5B, 8'hff);
    rd_reg(ADDR_RSVD_5B, 8'hfc);
    rd_reg(ADDR_LIM[0], 8'h52);
    for (int k = 0; k < 4; k++) report(5'h10 | 5'(1 << k), 6'h00);
    rd_reg(ADDR_ERR_FLAGS, 8'h0f);
    rd_reg(ADDR_ERR_FLAGS, 8'h00);
    rd_reg(ADDR_ERR_CNT, 8'h04);
    rd_reg(ADDR_ERR_CNT, 8'h00);
    acc = 8'h00;
    for (int l = 0; l < 2; l++) begin
      for (int f = 0; f < 3; f++) begin
        report(5'h00, 6'(1 << (3 * l + f)));
        acc = acc | 8'(1 << (4 * l + 1 + f));
        rd_reg(ADDR_LANE01, acc);
      end
    end
    rd_reg(ADDR_LANE01, 8'hee);
    wr_reg(ADDR_CONTROL, 8'h07);
    rd_reg(ADDR_CONTROL, 8'h03);
    rd_reg(ADDR_LANE01, 8'h00);
    wr_reg(ADDR_CONTROL, 8'h01);
    report(5'h1f, 6'h3f);
    rd_reg(ADDR_ERR_CNT, 8'h00);
    rd_reg(ADDR_LANE01, 8'h00);
    wr_reg(ADDR_CONTROL, 8'h03);
    repeat (300) report(5'h10, 6'h00);
    rd_reg(ADDR_ERR_CNT, 8'hff);
    // Bad packet lands in the same cycle as the clearing read
    fork
      report(5'h11, 6'h00);
      begin
        @(posedge clk);
        rd_reg(ADDR_ERR_CNT, 8'h00);
      end
    join
    rd_reg(ADDR_ERR_CNT, 8'h01);
    rd_reg(ADDR_ERR_FLAGS, 8'h01);
    sample(0, 3'h7);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(ADDR_ALARM_FLAGS, 8'h00);
    rd_reg(ADDR_EXT[0], 8'h07);
    repeat (2) @(posedge clk);
    close_out();
  end
endmodule // testbench
